// ---- mmcs_bp.sv ----
`timescale 1ns/1ns
// --------
// backplane lines with peer drivers
// --------
module mmcs_bp (
	// device side
	input  wire logic [7:0] dev_out,
	input  wire logic [7:0] dev_oe,
	// peer modules
	input  wire logic [7:0] peer_out,
	input  wire logic [7:0] peer_oe,
	// resolved lines
	output logic      [7:0] line
);
	// wired bus; a released line falls to its pull-down
	assign line = (dev_out & dev_oe) | (peer_out & peer_oe);
endmodule

// ---- mmcs_defs.svh ----
`ifndef MMCS_DEFS_SVH
`define MMCS_DEFS_SVH
// ----------------------------------------
// constants of the clock sync block
// ----------------------------------------
`define MMCS_TRIG_LINES      8
`define MMCS_TRIG_SEL_W      3
`define MMCS_SYNC_PULSE_LEN  4'h4
`define MMCS_OSR_DIV_W       8
`define MMCS_OSR_DIV_DEF     8'h04
`define MMCS_DELAY_W         24
`define MMCS_GD_DEF          24'h000100
`endif

// ---- mmcs_osr_gen.sv ----
`timescale 1ns/1ns
`include "mmcs_defs.svh"
// ----------------------------------------
// oversample clock divider with phase reset
// ----------------------------------------
module mmcs_osr_gen #(
	parameter int DW = `MMCS_OSR_DIV_W
) (
	// reference domain
	input  wire logic          ref_clk,
	input  wire logic          rst_b,
	// control
	input  wire logic [DW-1:0] half_div,
	input  wire logic          phase_rst,
	// output
	output logic               osr_clk
);
	logic [DW-1:0] cnt_reg;
	logic [DW-1:0] cnt_next;
	logic          osr_next;

	// sync pulse restarts the phase so all modules line up
	always_comb begin
		cnt_next = cnt_reg + 1'b1;
		osr_next = osr_clk;
		if (phase_rst) begin
			cnt_next = '0;
			osr_next = 1'b0;
		end else if (cnt_reg + 1'b1 >= half_div) begin
			cnt_next = '0;
			osr_next = ~osr_clk;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			osr_clk <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			osr_clk <= osr_next;
		end
	end
endmodule

// ---- mmcs_pkg.sv ----
// ----------------------------------------
// shared types
// ----------------------------------------
package mmcs_pkg;
	typedef enum logic [4:0] {
		MMCS_IDLE    = 5'h01,
		MMCS_ARMED   = 5'h02,
		MMCS_PULSE   = 5'h04,
		MMCS_SETTLE  = 5'h08,
		MMCS_READY   = 5'h10
	} mmcs_state_t;

	typedef struct packed {
		logic       sync_master;
		logic       start_master;
		logic       start_edge_fall;
		logic [2:0] sync_line;
		logic [2:0] start_line;
		logic       start_from_pfi;
	} mmcs_cfg_t;
endpackage

// ---- mmcs_sync2.sv ----
`timescale 1ns/1ns
`include "mmcs_defs.svh"
// ----------------------------------------
// two-flop level synchroniser
// ----------------------------------------
module mmcs_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	// second flop alone reads the first
	always_comb begin
		meta_next = d;
		q_next    = meta_reg;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= meta_next;
			q        <= q_next;
		end
	end
endmodule

// ---- mmcs_top.sv ----
`timescale 1ns/1ns
`include "mmcs_defs.svh"
// ----------------------------------------
// Behaviour
// - selected ref clock (onboard or backplane) drives oversample clock
// - ref source: onboard or backplane
// - sync master drives selected trigger line
// - sync pulse resets converters, oversample phase
// - sync slave takes pulse from line
// - start master role independent of sync
// - start slaves take the start edge from a trigger line or PFI; the start master drives no line
// - per-module start_master setting selects start role
// - slaves armed before master commits
// - master commit emits sync pulse
// - wait group delay before start
// - compensate output for filter delay
// - legacy 10 MHz never a ref source
// - start edge rising or falling
// ----------------------------------------
module mmcs_top #(
	parameter int                      TL = `MMCS_TRIG_LINES,
	parameter logic [`MMCS_DELAY_W-1:0] GROUP_DELAY = `MMCS_GD_DEF
) (
	// system side
	input  wire logic                       sys_clk,
	input  wire logic                       rst_b,
	// reference clock: already muxed by the clock mux cell
	input  wire logic                       ref_clk,
	// configuration (system domain, held static while used)
	input  wire logic                       ref_sel_backplane,
	input  wire mmcs_pkg::mmcs_cfg_t        cfg,
	input  wire logic [`MMCS_OSR_DIV_W-1:0] osr_half_div,
	input  wire logic [`MMCS_DELAY_W-1:0]   min_delay,
	input  wire logic                       arm,
	input  wire logic                       commit,
	input  wire logic                       start,
	// front trigger pin
	input  wire logic                       pfi_in,
	// backplane trigger lines, three-signal form
	input  wire logic [TL-1:0]              trig_in,
	output logic      [TL-1:0]              trig_out,
	output logic      [TL-1:0]              trig_oe,
	// converter side (reference domain)
	output logic                            osr_clk,
	output logic                            adc_reset,
	output logic                            acq_run,
	output logic [`MMCS_DELAY_W-1:0]        data_delay,
	// status (system domain)
	output logic                            ref_src_backplane,
	output logic                            synced,
	output logic                            running
);
	// ----------------------------------------
	// resets
	// ----------------------------------------
	logic [1:0] srst_reg;
	logic [1:0] srst_next;
	logic       sys_rst_b;
	logic [1:0] rrst_reg;
	logic [1:0] rrst_next;
	logic       ref_rst_b;

	// released through two flops in each domain
	always_comb begin
		srst_next = {srst_reg[0], 1'b1};
		rrst_next = {rrst_reg[0], 1'b1};
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) srst_reg <= 2'h0;
		else        srst_reg <= srst_next;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) rrst_reg <= 2'h0;
		else        rrst_reg <= rrst_next;
	end

	assign sys_rst_b = srst_reg[1];
	assign ref_rst_b = rrst_reg[1];

	// ----------------------------------------
	// control crossings into reference domain
	// ----------------------------------------
	logic       arm_tgl_reg, commit_tgl_reg, start_tgl_reg;
	logic       arm_tgl_next, commit_tgl_next, start_tgl_next;
	logic [2:0] tgl_ref;
	logic [2:0] tgl_d_reg;
	logic [2:0] tgl_d_next;
	logic       arm_ev, commit_ev, start_ev;
	logic       ref_bp_ref;

	// events travel as toggles, so a pulse is never lost
	always_comb begin
		arm_tgl_next    = arm_tgl_reg ^ arm;
		commit_tgl_next = commit_tgl_reg ^ commit;
		start_tgl_next  = start_tgl_reg ^ start;
	end

	always_ff @(posedge sys_clk or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			arm_tgl_reg    <= 1'b0;
			commit_tgl_reg <= 1'b0;
			start_tgl_reg  <= 1'b0;
		end else begin
			arm_tgl_reg    <= arm_tgl_next;
			commit_tgl_reg <= commit_tgl_next;
			start_tgl_reg  <= start_tgl_next;
		end
	end

	mmcs_sync2 #(.W(4)) u_ctl_sync (
		.clk   (ref_clk),
		.rst_b (ref_rst_b),
		.d     ({ref_sel_backplane, start_tgl_reg, commit_tgl_reg, arm_tgl_reg}),
		.q     ({ref_bp_ref, tgl_ref})
	);

	always_comb tgl_d_next = tgl_ref;

	always_ff @(posedge ref_clk or negedge ref_rst_b) begin
		if (!ref_rst_b) tgl_d_reg <= 3'h0;
		else            tgl_d_reg <= tgl_d_next;
	end

	assign arm_ev    = tgl_ref[0] ^ tgl_d_reg[0];
	assign commit_ev = tgl_ref[1] ^ tgl_d_reg[1];
	assign start_ev  = tgl_ref[2] ^ tgl_d_reg[2];

	// ----------------------------------------
	// trigger inputs
	// ----------------------------------------
	logic [TL:0] trig_s;
	logic        sync_lvl_reg, start_lvl_reg;
	logic        sync_lvl_next, start_lvl_next;
	logic        sync_in_ev, start_in_ev;
	logic        start_raw;

	// pins pass two flops before any edge logic
	mmcs_sync2 #(.W(TL + 1)) u_trig_sync (
		.clk   (ref_clk),
		.rst_b (ref_rst_b),
		.d     ({pfi_in, trig_in}),
		.q     (trig_s)
	);

	always_comb begin
		start_raw      = cfg.start_from_pfi ? trig_s[TL] : trig_s[cfg.start_line];
		sync_lvl_next  = trig_s[cfg.sync_line];
		start_lvl_next = start_raw;
	end

	always_ff @(posedge ref_clk or negedge ref_rst_b) begin
		if (!ref_rst_b) begin
			sync_lvl_reg  <= 1'b0;
			start_lvl_reg <= 1'b0;
		end else begin
			sync_lvl_reg  <= sync_lvl_next;
			start_lvl_reg <= start_lvl_next;
		end
	end

	// sync pulse is active high; start edge is chosen
	assign sync_in_ev  = trig_s[cfg.sync_line] & ~sync_lvl_reg;
	assign start_in_ev = cfg.start_edge_fall ? (~start_raw & start_lvl_reg)
	                                         : (start_raw & ~start_lvl_reg);

	// ----------------------------------------
	// sync and start sequencer
	// ----------------------------------------
	mmcs_pkg::mmcs_state_t st_reg, st_next;
	logic [3:0]               plen_reg, plen_next;
	logic [`MMCS_DELAY_W-1:0] wait_reg, wait_next;
	logic                     drive_reg, drive_next;
	logic                     adc_rst_next, run_next;
	logic [`MMCS_DELAY_W-1:0] settle;
	logic                     go;

	// master waits the longer of group delay and programmed delay
	assign settle = (cfg.sync_master && min_delay > GROUP_DELAY) ? min_delay
	                                                             : GROUP_DELAY;
	// start master fires from its own start; slaves follow the selected trigger line or PFI
	assign go = cfg.start_master ? start_ev : start_in_ev;

	always_comb begin
		st_next      = st_reg;
		plen_next    = plen_reg;
		wait_next    = wait_reg;
		drive_next   = 1'b0;
		adc_rst_next = 1'b0;
		run_next     = acq_run;
		case (st_reg)
			mmcs_pkg::MMCS_IDLE: begin
				run_next = 1'b0;
				if (cfg.sync_master && commit_ev) begin
					st_next   = mmcs_pkg::MMCS_PULSE;
					plen_next = `MMCS_SYNC_PULSE_LEN;
				end else if (!cfg.sync_master && arm_ev) begin
					st_next = mmcs_pkg::MMCS_ARMED;
				end
			end
			mmcs_pkg::MMCS_ARMED: begin
				if (sync_in_ev) begin
					st_next      = mmcs_pkg::MMCS_SETTLE;
					wait_next    = settle;
					adc_rst_next = 1'b1;
				end
			end
			mmcs_pkg::MMCS_PULSE: begin
				drive_next   = 1'b1;
				adc_rst_next = 1'b1;
				plen_next    = plen_reg - 4'h1;
				// drive stays up through the last cycle, so the line sees the full length
				if (plen_reg == 4'h1) begin
					st_next    = mmcs_pkg::MMCS_SETTLE;
					wait_next  = settle;
				end
			end
			mmcs_pkg::MMCS_SETTLE: begin
				if (wait_reg <= 1) st_next = mmcs_pkg::MMCS_READY;
				else               wait_next = wait_reg - 1'b1;
			end
			mmcs_pkg::MMCS_READY: begin
				if (go) run_next = 1'b1;
				if (arm_ev && !cfg.sync_master) begin
					st_next  = mmcs_pkg::MMCS_ARMED;
					run_next = 1'b0;
				end
			end
			default: st_next = mmcs_pkg::MMCS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge ref_rst_b) begin
		if (!ref_rst_b) begin
			st_reg    <= mmcs_pkg::MMCS_IDLE;
			plen_reg  <= 4'h0;
			wait_reg  <= '0;
			drive_reg <= 1'b0;
			adc_reset <= 1'b0;
			acq_run   <= 1'b0;
		end else begin
			st_reg    <= st_next;
			plen_reg  <= plen_next;
			wait_reg  <= wait_next;
			drive_reg <= drive_next;
			adc_reset <= adc_rst_next;
			acq_run   <= run_next;
		end
	end

	// ----------------------------------------
	// trigger line drive and data timing
	// ----------------------------------------
	logic [TL-1:0] tout_next;
	logic [`MMCS_DELAY_W-1:0] dd_next;

	always_comb begin
		tout_next = '0;
		if (drive_reg) tout_next[cfg.sync_line] = 1'b1;
		dd_next = GROUP_DELAY;
	end

	always_ff @(posedge ref_clk or negedge ref_rst_b) begin
		if (!ref_rst_b) begin
			trig_out   <= '0;
			trig_oe    <= '0;
			data_delay <= '0;
		end else begin
			trig_out   <= tout_next;
			trig_oe    <= tout_next;
			data_delay <= dd_next;
		end
	end

	// oversample clock restarts on every sync pulse
	mmcs_osr_gen u_osr (
		.ref_clk   (ref_clk),
		.rst_b     (ref_rst_b),
		.half_div  (osr_half_div),
		.phase_rst (adc_rst_next),
		.osr_clk   (osr_clk)
	);

	// ----------------------------------------
	// status back to system domain
	// ----------------------------------------
	logic [2:0] stat_s;
	logic       rdy_lvl;
	logic [2:0] stat_next;
	logic       src_next;

	assign rdy_lvl = (st_reg == mmcs_pkg::MMCS_READY);

	mmcs_sync2 #(.W(3)) u_stat_sync (
		.clk   (sys_clk),
		.rst_b (sys_rst_b),
		.d     ({ref_bp_ref, acq_run, rdy_lvl}),
		.q     (stat_s)
	);

	// only two sources exist; the legacy 10 MHz is not one
	always_comb begin
		stat_next = stat_s;
		src_next  = ref_sel_backplane;
	end

	always_ff @(posedge sys_clk or negedge sys_rst_b) begin
		if (!sys_rst_b) begin
			synced            <= 1'b0;
			running           <= 1'b0;
			ref_src_backplane <= 1'b0;
		end else begin
			synced            <= stat_next[0];
			running           <= stat_next[1];
			ref_src_backplane <= src_next;
		end
	end
endmodule

// ---- mmcs_top_sva.sv ----
`timescale 1ns/1ns
`include "mmcs_defs.svh"
// --------
// port checker
// --------
module mmcs_top_sva #(
	parameter int                       TL          = `MMCS_TRIG_LINES,
	parameter logic [`MMCS_DELAY_W-1:0] GROUP_DELAY = `MMCS_GD_DEF
) (
	// clocks and reset
	input wire logic                     sys_clk,
	input wire logic                     rst_b,
	input wire logic                     ref_clk,
	// configuration
	input wire logic                     ref_sel_backplane,
	input wire mmcs_pkg::mmcs_cfg_t      cfg,
	// watched outputs
	input wire logic [TL-1:0]            trig_out,
	input wire logic [TL-1:0]            trig_oe,
	input wire logic                     adc_reset,
	input wire logic                     acq_run,
	input wire logic [`MMCS_DELAY_W-1:0] data_delay,
	input wire logic                     ref_src_backplane,
	input wire logic                     synced,
	input wire logic                     running
);
	// rest of a four-cycle pulse after its first cycle
	sequence s_drive_rest;
		trig_oe[cfg.sync_line] [*3] ##1 !trig_oe[cfg.sync_line];
	endsequence
	sequence s_reset_rest;
		adc_reset [*3] ##1 !adc_reset;
	endsequence
	// line driving
	a_out_gated: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(trig_out & ~trig_oe) == '0) else $error("trig_out high while released");
	a_one_line: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$onehot0(trig_oe)) else $error("more than one line driven");
	a_slave_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!cfg.sync_master && !cfg.start_master |-> trig_oe == '0)
		else $error("slave drives a line");
	a_drive_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(trig_oe[cfg.sync_line]) |=> s_drive_rest)
		else $error("sync drive not four cycles");
	// converter reset length and order, and data delay
	a_pulse_order: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(adc_reset) && cfg.sync_master |-> ##[0:2] trig_oe[cfg.sync_line])
		else $error("master reset without drive");
	a_reset_len: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(adc_reset) && cfg.sync_master |=> s_reset_rest)
		else $error("master adc_reset not four cycles");
	a_slave_short: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(adc_reset) && !cfg.sync_master |=> !adc_reset)
		else $error("slave adc_reset not one cycle");
	a_delay_comp: assert property (@(posedge ref_clk) disable iff (!rst_b)
		acq_run |-> data_delay == GROUP_DELAY) else $error("data_delay wrong");
	// status in the system domain
	a_start_ready: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$rose(running) |-> synced) else $error("running before synced");
	a_src_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
		$changed(ref_sel_backplane) |-> ##[1:4] ref_src_backplane == ref_sel_backplane)
		else $error("ref source not followed");
endmodule

bind mmcs_top mmcs_top_sva #(.TL(TL), .GROUP_DELAY(GROUP_DELAY)) mmcs_top_sva_i (
	.sys_clk(sys_clk), .rst_b(rst_b), .ref_clk(ref_clk),
	.ref_sel_backplane(ref_sel_backplane), .cfg(cfg), .trig_out(trig_out),
	.trig_oe(trig_oe), .adc_reset(adc_reset), .acq_run(acq_run), .data_delay(data_delay),
	.ref_src_backplane(ref_src_backplane), .synced(synced), .running(running));

// ---- mmcs_top_test.sv ----
`timescale 1ns/1ns
`include "mmcs_defs.svh"
module mmcs_top_test;
	// --------
	// rows and signals
	// --------
	typedef struct packed {
		logic        sm;
		logic        st;
		logic        fall;
		logic        pfi;
		logic [2:0]  sl;
		logic [2:0]  tl;
		logic [23:0] md;
	} mmcs_row_t;
	localparam logic [23:0] GD = 24'h000010; // short filter delay keeps the run brief
	mmcs_row_t           rows [5];
	mmcs_row_t           r;
	mmcs_pkg::mmcs_cfg_t cfg;
	logic                sys_clk = 1'b0;
	logic                ref_clk = 1'b0;
	logic                rst_b, sel, arm, commit, start, pfi;
	logic [23:0]         md, dd;
	logic [7:0]          pout, poe, line, tout, toe;
	logic                osr, adcr, run, srcb, synced, running;
	logic                o0;
	int                  miscompares = 0;
	int                  n_tests = 0;
	int                  rcnt = 0;
	int                  mx, m;
	always #5 sys_clk = ~sys_clk;
	// link clock, phase unrelated to sys_clk
	initial begin
		#7;
		forever #32 ref_clk = ~ref_clk;
	end
	// ref cycles since the sync line fell
	always @(posedge ref_clk) rcnt <= line[cfg.sync_line] ? 0 : rcnt + 1;
	mmcs_top #(.GROUP_DELAY(GD)) mmcs_top_i (
		.sys_clk(sys_clk), .rst_b(rst_b), .ref_clk(ref_clk), .ref_sel_backplane(sel),
		.cfg(cfg), .osr_half_div(8'h02), .min_delay(md), .arm(arm), .commit(commit),
		.start(start), .pfi_in(pfi), .trig_in(line), .trig_out(tout), .trig_oe(toe),
		.osr_clk(osr), .adc_reset(adcr), .acq_run(run), .data_delay(dd),
		.ref_src_backplane(srcb), .synced(synced), .running(running));
	mmcs_bp mmcs_bp_i (.dev_out(tout), .dev_oe(toe), .peer_out(pout), .peer_oe(poe),
		.line(line));
	// --------
	// tasks
	// --------
	task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// held over three ref edges too, so both domains clear
	task do_reset;
		rst_b = 1'b0;
		repeat (16) @(negedge sys_clk);
		repeat (3) @(posedge ref_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		repeat (40) @(negedge sys_clk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		int i;
		for (i = 0; i < lim && s !== 1'b1; i++) @(negedge sys_clk);
		if (i == lim) begin
			miscompares++;
			$display("[ERR] wait exp 1 seen %b", s);
			end_of_test;
		end
	endtask
	// --------
	// main sequence
	// --------
	initial begin
		{rst_b, sel, arm, commit, start, pfi} = 6'b010000;
		cfg = '0;
		md = '0;
		pout = '0;
		poe = '0;
		rows = '{{4'b1100, 3'h2, 3'h0, 24'h000000}, {4'b1010, 3'h7, 3'h3, 24'h000028},
			{4'b0100, 3'h2, 3'h0, 24'h000000}, {4'b0011, 3'h0, 3'h0, 24'h000000},
			{4'b0000, 3'h4, 3'h6, 24'h000030}};
		for (m = 0; m < 5; m++) begin
			r = rows[m];
			cfg = '{r.sm, r.st, r.fall, r.sl, r.tl, r.pfi};
			md = r.md;
			pout = '0;
			poe = '0;
			pout[r.tl] = r.fall; // idle level ahead of the start edge
			poe[r.tl] = !r.pfi;
			pfi = r.fall;
			do_reset;
			if (r.sm) pulse(commit);
			else begin
				pulse(arm);
				repeat (6) @(posedge ref_clk);
				@(negedge sys_clk);
				pout[r.sl] = 1'b1;
				poe[r.sl] = 1'b1;
				repeat (4) @(posedge ref_clk);
				@(negedge sys_clk);
				poe[r.sl] = 1'b0;
				pout[r.sl] = 1'b0;
			end
			pulse(start); // too early, must be ignored
			wait_hi(synced, 3000);
			mx = (r.sm && r.md > GD) ? r.md : GD;
			check("settle", 24'(rcnt + 8 >= mx && rcnt <= mx + 12), 24'h000001);
			check("early start", running, 24'h000000);
			if (r.st) pulse(start);
			else if (r.pfi) pfi = !r.fall;
			else pout[r.tl] = !r.fall;
			wait_hi(running, 500);
			check("acq_run", run, 24'h000001);
			check("data_delay", dd, GD);
			// half divider of two: the oversample clock flips every two ref edges
			@(posedge ref_clk);
			#1 o0 = osr;
			repeat (2) @(posedge ref_clk);
			#1 check("osr_clk", {23'h0, osr}, {23'h0, ~o0});
			@(negedge sys_clk);
			$display("row %0d done", m);
		end
		// a reset in mid-run clears the outputs at once
		rst_b = 1'b0;
		@(negedge sys_clk);
		check("running", running, 24'h000000);
		check("trig_oe", toe, 24'h000000);
		check("acq_run", run, 24'h000000);
		cfg = '0;
		do_reset;
		pulse(commit);
		repeat (40) @(negedge sys_clk);
		check("slave drive", toe, 24'h000000);
		sel = 1'b0;
		repeat (6) @(negedge sys_clk);
		check("ref_src", srcb, 24'h000000);
		sel = 1'b1;
		repeat (6) @(negedge sys_clk);
		check("ref_src", srcb, 24'h000001);
		$display("hand tests done");
		end_of_test;
	end
endmodule
